// ### design/cpcsr_map.vh
// register map, field positions, reset values and timing counts of the copper control/status bank
`ifndef CPCSR_MAP_VH
`define CPCSR_MAP_VH

// ***************************************************************************
// register indices (byte address is four times the index)
// ***************************************************************************
`define CPCSR_IDX_CTRL        6'h00
`define CPCSR_IDX_STAT        6'h01
`define CPCSR_IDX_CUCTRL      6'h02
`define CPCSR_IDX_MACCTRL     6'h03
`define CPCSR_IDX_IRQ_STAT    6'h04
`define CPCSR_IDX_IRQ_MASK    6'h05
`define CPCSR_IDX_APPLIED     6'h06

// ***************************************************************************
// control word fields
// ***************************************************************************
`define CPCSR_CTRL_SRST       15
`define CPCSR_CTRL_SPD_LSB    13
`define CPCSR_CTRL_PDOWN      11
`define CPCSR_CTRL_ISO        10
`define CPCSR_CTRL_ANRST      9
`define CPCSR_CTRL_DUPLEX     8
`define CPCSR_CTRL_COLTEST    7
`define CPCSR_CTRL_SPD_MSB    6

// ***************************************************************************
// own control words
// ***************************************************************************
`define CPCSR_CUCTRL_PDOWN    2
`define CPCSR_MACCTRL_KEEP    3

// ***************************************************************************
// status word: fixed part and live fields
// ***************************************************************************
`define CPCSR_STAT_FIXED      16'h7949
`define CPCSR_STAT_ANDONE     5
`define CPCSR_STAT_RFAULT     4

// ***************************************************************************
// interrupt events
// ***************************************************************************
`define CPCSR_IRQ_W           3
`define CPCSR_IRQ_ANDONE      0
`define CPCSR_IRQ_RFAULT      1
`define CPCSR_IRQ_SRSTDONE    2

// ***************************************************************************
// reset values and the reserved speed code
// ***************************************************************************
`define CPCSR_RST_DUPLEX      1'b1
`define CPCSR_RST_SPEED       2'h2
`define CPCSR_SPEED_RSVD      2'h3

// ***************************************************************************
// timing: soft reset length
// ***************************************************************************
`define CPCSR_CLK_MHZ         100
`define CPCSR_SRST_NS         200
`define CPCSR_SRST_CYC        ((`CPCSR_SRST_NS * `CPCSR_CLK_MHZ + 999) / 1000)

`endif

// ### design/cpcsr_w1c.v
// sticky event flags, set by hardware, cleared by writing one, set wins
`timescale 1ns/1ps
`default_nettype none

module cpcsr_w1c #(
  parameter W = 3
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] set_i,
  input  wire [W-1:0] clr_i,
  output reg  [W-1:0] q_o
);

  // set has priority over a clear in the same cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= {W{1'b0}};
    end else begin
      q_o <= set_i | (q_o & ~clr_i);
    end
  end

endmodule // cpcsr_w1c

`default_nettype wire

// ### design/cpcsr_timer.v
// one-shot cycle timer: busy for a fixed count, then a done pulse
`timescale 1ns/1ps
`default_nettype none

module cpcsr_timer #(
  parameter [7:0] CYCLES = 8'h14
) (
  input  wire clk_i,
  input  wire rst_i,
  input  wire start_i,
  output reg  busy_o,
  output reg  done_o
);

  reg [7:0] cnt_q;

  // a start while busy restarts the count
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= 8'h00;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        cnt_q  <= CYCLES;
        busy_o <= 1'b1;
      end else if (busy_o) begin
        if (cnt_q == 8'h01) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

endmodule // cpcsr_timer

`default_nettype wire

// ### design/cpcsr_top.v
// copper control and status register bank with wishbone slave and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "cpcsr_map.vh"

module cpcsr_top (
  input  wire        clk_i,
  input  wire        rst_i,
  // classic wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // transceiver core side
  input  wire        an_done_i,
  input  wire        remote_fault_i,
  output reg         phy_reset_o,
  output reg         an_restart_o,
  output reg         duplex_o,
  output reg  [1:0]  speed_o,
  output reg         power_down_o,
  output reg         rgmii_en_o,
  output reg         isolate_o,
  output reg         irq_o
);

  // ***************************************************************************
  // local constants
  // ***************************************************************************
  localparam integer SRST_CYC_I  = `CPCSR_SRST_CYC;
  localparam [7:0]   SRST_CYCLES = SRST_CYC_I[7:0];    // count fits eight bits

  // ***************************************************************************
  // declarations
  // ***************************************************************************
  wire        acc;
  wire        wr;
  wire        rd;
  wire [5:0]  idx;
  wire        wr_ctrl;
  wire        wr_cu;
  wire        wr_mac;
  wire        wr_imask;
  wire        wr_istat;
  wire        rd_stat;
  wire        lane0;
  wire        lane1;

  reg         pd_q;
  reg         iso_q;
  reg         anr_q;
  reg         dup_pend_q;
  reg  [1:0]  spd_pend_q;
  reg         cu_pd_q;
  reg         keep_q;
  reg  [`CPCSR_IRQ_W-1:0] imask_q;
  reg         hw_an_q;
  reg         pd_prev_q;
  reg         an_done_q;
  reg         rf_q;
  reg         dup_app_q;
  reg  [1:0]  spd_app_q;

  reg         pd_d;
  reg         dup_pend_d;
  reg  [1:0]  spd_pend_d;
  reg         cu_pd_d;
  reg         srst_wr;
  reg         anr_wr;
  reg  [15:0] ctrl_rd;
  reg  [15:0] stat_rd;
  reg  [31:0] rd_d;

  wire        pd_eff_d;
  wire        pd_exit;
  wire        apply;
  wire        srst_start;
  wire        srst_busy;
  wire        srst_done;
  wire        an_done_d;
  wire        rf_d;
  wire [`CPCSR_IRQ_W-1:0] ev_set;
  wire [`CPCSR_IRQ_W-1:0] ev_clr;
  wire [`CPCSR_IRQ_W-1:0] istat;

  // ***************************************************************************
  // wishbone access decode
  // ***************************************************************************
  // one access per request, answered in the next cycle
  assign acc      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr       = acc & wb_we_i;
  assign rd       = acc & ~wb_we_i;
  assign idx      = wb_adr_i[7:2];
  assign lane0    = wb_sel_i[0];
  assign lane1    = wb_sel_i[1];
  assign wr_ctrl  = wr & (idx == `CPCSR_IDX_CTRL);
  assign wr_cu    = wr & (idx == `CPCSR_IDX_CUCTRL);
  assign wr_mac   = wr & (idx == `CPCSR_IDX_MACCTRL);
  assign wr_imask = wr & (idx == `CPCSR_IDX_IRQ_MASK);
  assign wr_istat = wr & (idx == `CPCSR_IDX_IRQ_STAT);
  assign rd_stat  = rd & (idx == `CPCSR_IDX_STAT);

  // ***************************************************************************
  // next values of written control bits
  // ***************************************************************************
  // byte lanes gate each half of the control word
  always @* begin
    pd_d       = pd_q;
    dup_pend_d = dup_pend_q;
    spd_pend_d = spd_pend_q;
    cu_pd_d    = cu_pd_q;
    srst_wr    = 1'b0;
    anr_wr     = 1'b0;
    if (wr_ctrl && lane1) begin
      srst_wr       = wb_dat_i[`CPCSR_CTRL_SRST];
      anr_wr        = wb_dat_i[`CPCSR_CTRL_ANRST];
      pd_d          = wb_dat_i[`CPCSR_CTRL_PDOWN];
      dup_pend_d    = wb_dat_i[`CPCSR_CTRL_DUPLEX];
      spd_pend_d[0] = wb_dat_i[`CPCSR_CTRL_SPD_LSB];
    end
    if (wr_ctrl && lane0) begin
      spd_pend_d[1] = wb_dat_i[`CPCSR_CTRL_SPD_MSB];
    end
    if (wr_cu && lane0) begin
      cu_pd_d = wb_dat_i[`CPCSR_CUCTRL_PDOWN];
    end
  end

  // ***************************************************************************
  // power down and apply events
  // ***************************************************************************
  // powered down while either bit is set
  assign pd_eff_d   = pd_d | cu_pd_d;
  assign pd_exit    = pd_prev_q & ~pd_eff_d;
  // leaving power down also kicks a soft reset
  assign srst_start = srst_wr | pd_exit;
  assign apply      = srst_start | anr_wr;

  // soft reset length counter
  cpcsr_timer #(
    .CYCLES  (SRST_CYCLES)
  ) u_srst (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (srst_start),
    .busy_o  (srst_busy),
    .done_o  (srst_done)
  );

  // ***************************************************************************
  // control register state
  // ***************************************************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      pd_q       <= 1'b0;
      iso_q      <= 1'b0;
      anr_q      <= 1'b0;
      dup_pend_q <= `CPCSR_RST_DUPLEX;
      spd_pend_q <= `CPCSR_RST_SPEED;
      cu_pd_q    <= 1'b0;
      keep_q     <= 1'b0;
      imask_q    <= {`CPCSR_IRQ_W{1'b0}};
      pd_prev_q  <= 1'b0;
      dup_app_q  <= `CPCSR_RST_DUPLEX;
      spd_app_q  <= `CPCSR_RST_SPEED;
    end else begin
      pd_q       <= pd_d;
      cu_pd_q    <= cu_pd_d;
      dup_pend_q <= dup_pend_d;
      spd_pend_q <= spd_pend_d;
      pd_prev_q  <= pd_eff_d;
      // restart request holds one cycle then clears itself
      anr_q      <= anr_wr | pd_exit;
      // isolate follows software, cleared by soft reset
      if (srst_start) begin
        iso_q <= 1'b0;
      end else if (wr_ctrl && lane1) begin
        iso_q <= wb_dat_i[`CPCSR_CTRL_ISO];
      end
      if (wr_mac && lane0) begin
        keep_q <= wb_dat_i[`CPCSR_MACCTRL_KEEP];
      end
      if (wr_imask && lane0) begin
        imask_q <= wb_dat_i[`CPCSR_IRQ_W-1:0];
      end
      // pending mode reaches the core only on an apply event
      if (apply) begin
        dup_app_q <= dup_pend_d;
        if (spd_pend_d != `CPCSR_SPEED_RSVD) begin
          spd_app_q <= spd_pend_d;
        end
      end
    end
  end

  // ***************************************************************************
  // hardware reset restart request
  // ***************************************************************************
  // set by reset, consumed in the first cycle after release
  always @(posedge clk_i) begin
    if (rst_i) begin
      hw_an_q <= 1'b1;
    end else begin
      hw_an_q <= 1'b0;
    end
  end

  // ***************************************************************************
  // status bits
  // ***************************************************************************
  // completion is forced low while the core is held in reset
  assign an_done_d = an_done_i & ~srst_busy;
  // fault latch, a new fault beats the read clear
  assign rf_d      = remote_fault_i | (rf_q & ~rd_stat);

  always @(posedge clk_i) begin
    if (rst_i) begin
      an_done_q <= 1'b0;
      rf_q      <= 1'b0;
    end else begin
      an_done_q <= an_done_d;
      rf_q      <= rf_d;
    end
  end

  // ***************************************************************************
  // interrupt flags
  // ***************************************************************************
  assign ev_set[`CPCSR_IRQ_ANDONE]   = an_done_d & ~an_done_q;
  assign ev_set[`CPCSR_IRQ_RFAULT]   = remote_fault_i & ~rf_q;
  assign ev_set[`CPCSR_IRQ_SRSTDONE] = srst_done;
  assign ev_clr = (wr_istat && lane0) ? wb_dat_i[`CPCSR_IRQ_W-1:0] : {`CPCSR_IRQ_W{1'b0}};

  cpcsr_w1c #(
    .W     (`CPCSR_IRQ_W)
  ) u_irq (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .set_i (ev_set),
    .clr_i (ev_clr),
    .q_o   (istat)
  );

  // ***************************************************************************
  // read data assembly
  // ***************************************************************************
  // reserved bits and the collision test bit stay zero
  always @* begin
    ctrl_rd                       = 16'h0000;
    ctrl_rd[`CPCSR_CTRL_SRST]     = srst_busy;
    ctrl_rd[`CPCSR_CTRL_SPD_LSB]  = spd_pend_q[0];
    ctrl_rd[`CPCSR_CTRL_PDOWN]    = pd_q;
    ctrl_rd[`CPCSR_CTRL_ISO]      = iso_q;
    ctrl_rd[`CPCSR_CTRL_ANRST]    = anr_q;
    ctrl_rd[`CPCSR_CTRL_DUPLEX]   = dup_pend_q;
    ctrl_rd[`CPCSR_CTRL_SPD_MSB]  = spd_pend_q[1];
  end

  // fixed abilities plus the two live fields
  always @* begin
    stat_rd                       = `CPCSR_STAT_FIXED;
    stat_rd[`CPCSR_STAT_ANDONE]   = an_done_q;
    stat_rd[`CPCSR_STAT_RFAULT]   = rf_q;
  end

  // unmapped addresses read zero
  always @* begin
    rd_d = 32'h0000_0000;
    case (idx)
      `CPCSR_IDX_CTRL: begin
        rd_d[15:0] = ctrl_rd;
      end
      `CPCSR_IDX_STAT: begin
        rd_d[15:0] = stat_rd;
      end
      `CPCSR_IDX_CUCTRL: begin
        rd_d[`CPCSR_CUCTRL_PDOWN] = cu_pd_q;
      end
      `CPCSR_IDX_MACCTRL: begin
        rd_d[`CPCSR_MACCTRL_KEEP] = keep_q;
      end
      `CPCSR_IDX_IRQ_STAT: begin
        rd_d[`CPCSR_IRQ_W-1:0] = istat;
      end
      `CPCSR_IDX_IRQ_MASK: begin
        rd_d[`CPCSR_IRQ_W-1:0] = imask_q;
      end
      `CPCSR_IDX_APPLIED: begin
        rd_d[5:0] = {rgmii_en_o, power_down_o, isolate_o, dup_app_q, spd_app_q};
      end
      default: begin
        rd_d = 32'h0000_0000;
      end
    endcase
  end

  // ***************************************************************************
  // wishbone answer
  // ***************************************************************************
  // ack one cycle after the request, dropped the cycle after
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      if (rd) begin
        wb_dat_o <= rd_d;
      end
    end
  end

  // ***************************************************************************
  // core-facing outputs
  // ***************************************************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      phy_reset_o  <= 1'b1;
      an_restart_o <= 1'b0;
      duplex_o     <= `CPCSR_RST_DUPLEX;
      speed_o      <= `CPCSR_RST_SPEED;
      power_down_o <= 1'b0;
      rgmii_en_o   <= 1'b1;
      isolate_o    <= 1'b0;
      irq_o        <= 1'b0;
    end else begin
      // core held in reset while the soft reset runs
      phy_reset_o  <= srst_busy;
      // restart after any reset, a software request or a wake
      an_restart_o <= anr_q | hw_an_q | srst_done;
      duplex_o     <= dup_app_q;
      speed_o      <= spd_app_q;
      power_down_o <= pd_prev_q;
      // mac interface stays up in power down only with keep-alive
      rgmii_en_o   <= ~pd_prev_q | keep_q;
      isolate_o    <= iso_q;
      irq_o        <= |(istat & imask_q);
    end
  end

endmodule // cpcsr_top

`default_nettype wire

// ### bench/cpcsr_top_props.sv
// port-level checks of the copper control/status bank
`timescale 1ns/1ps
`default_nettype none
module cpcsr_top_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        phy_reset_o,
  input wire logic        an_restart_o,
  input wire logic        duplex_o,
  input wire logic [1:0]  speed_o,
  input wire logic        irq_o
);
  // ***************************************************************
  // decoded bus events and sequences
  // ***************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire take_w  = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h00 && wb_sel_i[1];
  wire stat_rd = wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h01;
  wire ctrl_rd = wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h00;
  sequence s_srst_take;
    take_w && wb_dat_i[15];
  endsequence
  sequence s_srst_hold;
    ##2 phy_reset_o [*8] ##1 phy_reset_o [*8] ##1 phy_reset_o [*4] ##1 !phy_reset_o;
  endsequence
  // ***************************************************************
  // assertions
  // ***************************************************************
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  AST_STAT_ONES: assert property (stat_rd |-> wb_dat_o[14:11] == 4'hF)
    else $error("ability ones missing");
  AST_STAT_ZEROS: assert property (stat_rd |-> {wb_dat_o[15], wb_dat_o[10:9]} == 3'h0)
    else $error("ability zeros wrong");
  AST_STAT_EXT: assert property (stat_rd |-> wb_dat_o[8]) else $error("extended status bit low");
  AST_STAT_PRE: assert property (stat_rd |-> wb_dat_o[6] && wb_dat_o[3])
    else $error("preamble or negotiation ability low");
  AST_RSVD7: assert property (stat_rd || ctrl_rd |-> !wb_dat_o[7]) else $error("bit 7 set");
  AST_RSVD_CTRL: assert property (ctrl_rd |-> wb_dat_o[5:0] == 6'h00) else $error("ctrl low bits set");
  AST_SRST_LEN: assert property (s_srst_take |-> s_srst_hold) else $error("soft reset length");
  AST_RESTART: assert property (take_w && wb_dat_i[9] |-> ##[1:3] an_restart_o)
    else $error("restart pulse missing");
  AST_RESTART_PULSE: assert property (an_restart_o |=> !an_restart_o) else $error("restart not a pulse");
  AST_RST_RESTART: assert property ($fell(phy_reset_o) |-> ##[0:2] an_restart_o)
    else $error("no restart after reset");
  AST_APPLY: assert property (duplex_o != $past(duplex_o) || speed_o != $past(speed_o) |->
    $past(wb_cyc_i && wb_stb_i && wb_we_i, 2)) else $error("mode changed without write");
endmodule // cpcsr_top_props
bind cpcsr_top cpcsr_top_props i_cpcsr_top_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .phy_reset_o(phy_reset_o), .an_restart_o(an_restart_o),
  .duplex_o(duplex_o), .speed_o(speed_o), .irq_o(irq_o));
`default_nettype wire

// ### bench/cpcsr_mgmt_model.sv
// management controller model: classic wishbone master
`timescale 1ns/1ps
`default_nettype none
module cpcsr_mgmt_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output var  logic        cyc_o,
  output var  logic        stb_o,
  output var  logic        we_o,
  output var  logic [7:0]  adr_o,
  output var  logic [3:0]  sel_o,
  output var  logic [31:0] dat_o
);
  // idle bus at time zero
  initial begin
    cyc_o = 1'h0;
    stb_o = 1'h0;
    we_o  = 1'h0;
    adr_o = 8'hFF;
    sel_o = 4'h0;
    dat_o = 32'hA5A5_A5A5;
  end
  // one access, held until ack is seen, then released with scrambled lines
  task automatic wb_rw(input logic we, input logic [7:0] adr, input logic [15:0] wd, output logic [15:0] rd);
    @(posedge clk_i);
    cyc_o <= 1'h1;
    stb_o <= 1'h1;
    we_o  <= we;
    adr_o <= adr;
    sel_o <= 4'h3;
    dat_o <= {16'h0000, wd};
    rd = 16'hXXXX;
    // no own limit: only the bench watchdog ends a hung wait
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'h1);
    rd = dat_i[15:0];
    cyc_o <= 1'h0;
    stb_o <= 1'h0;
    sel_o <= 4'h0;
    adr_o <= ~adr;
    dat_o <= ~{16'h0000, wd};
  endtask
endmodule // cpcsr_mgmt_model
`default_nettype wire

// ### bench/cpcsr_top_tb.sv
// self-checking bench of the copper control/status bank
`timescale 1ns/1ps
`default_nettype none
`include "cpcsr_map.vh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module cpcsr_top_tb;
  typedef struct {logic we; logic [7:0] a; logic [15:0] d; logic [15:0] e; logic dup; logic [1:0] spd;} cpcsr_row_t;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        an_done_i = 1'h0;
  logic        remote_fault_i = 1'h0;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        phy_reset_o, an_restart_o, duplex_o, power_down_o, rgmii_en_o, isolate_o, irq_o;
  logic [1:0]  speed_o;
  int          mismatches = 0, checked = 0, restarts = 0, srst = 0;
  logic [1:0]  seq [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
  // we, address, write data, read expectation, applied duplex, applied speed
  cpcsr_row_t  rows [11] = '{'{0, 8'h00, 0, 16'h0140, 1, 2}, '{0, 8'h04, 0, 16'h7949, 1, 2},
    '{0, 8'h18, 0, 16'h0026, 1, 2}, '{1, 8'h00, 16'h20BF, 0, 1, 2}, '{0, 8'h00, 0, 16'h2000, 1, 2},
    '{1, 8'h20, 16'hFFFF, 0, 1, 2}, '{0, 8'h20, 0, 0, 1, 2}, '{0, 8'h08, 0, 0, 1, 2},
    '{0, 8'h0C, 0, 0, 1, 2}, '{0, 8'h10, 0, 0, 1, 2}, '{0, 8'h14, 0, 0, 1, 2}};
  // ***************************************************************
  // clock, monitors, design and bus master
  // ***************************************************************
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (an_restart_o === 1'h1) restarts++;
    if (phy_reset_o === 1'h1 && !rst_i) srst++;
  end
  cpcsr_top i_cpcsr_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .an_done_i(an_done_i), .remote_fault_i(remote_fault_i), .phy_reset_o(phy_reset_o),
    .an_restart_o(an_restart_o), .duplex_o(duplex_o), .speed_o(speed_o), .power_down_o(power_down_o),
    .rgmii_en_o(rgmii_en_o), .isolate_o(isolate_o), .irq_o(irq_o));
  cpcsr_mgmt_model i_cpcsr_mgmt_model (.clk_i(clk_i), .ack_i(wb_ack_o), .dat_i(wb_dat_o), .cyc_o(wb_cyc_i),
    .stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i));
  // ***************************************************************
  // helpers
  // ***************************************************************
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] r;
    i_cpcsr_mgmt_model.wb_rw(1'h1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] r);
    i_cpcsr_mgmt_model.wb_rw(1'h0, a, 16'h0000, r);
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog well beyond the expected few hundred cycles
  initial begin
    w(8000);
    mismatches++;
    wrap_up;
  end
  // ***************************************************************
  // tests
  // ***************************************************************
  initial begin
    logic [15:0] r, cv;
    logic [1:0]  sp;
    int          r0, s0;
    w(12);
    rst_i <= 1'h0;
    foreach (rows[i]) begin
      if (rows[i].we) wr(rows[i].a, rows[i].d);
      else begin
        rd(rows[i].a, r);
        `CHK("read", rows[i].e, r)
      end
      w(3);
      `CHK("duplex", rows[i].dup, duplex_o)
      `CHK("speed", rows[i].spd, speed_o)
    end
    $display("test table done");
    sp = 2'h2;
    foreach (seq[i]) begin
      r0 = restarts;
      cv = {2'h0, seq[i][0], 3'h0, 1'h1, seq[i] == 2'h0, 1'h0, seq[i][1], 6'h00};
      wr(8'h00, cv);
      w(3);
      if (seq[i] != 2'h3) sp = seq[i];
      `CHK("restarts", r0 + 1, restarts)
      `CHK("speed", sp, speed_o)
      `CHK("duplex", cv[8], duplex_o)
      rd(8'h00, r);
      `CHK("ctrl", cv & 16'hFDFF, r)
    end
    $display("test speed done");
    wr(8'h00, 16'h2440);
    w(2);
    `CHK("isolate", 1'h1, isolate_o)
    rd(8'h04, r);
    `CHK("status", 16'h7949, r)
    r0 = restarts;
    s0 = srst;
    wr(8'h00, 16'h8140);
    w(30);
    `CHK("srst cycles", `CPCSR_SRST_CYC, srst - s0)
    `CHK("restarts", r0 + 1, restarts)
    `CHK("isolate", 1'h0, isolate_o)
    `CHK("duplex", 1'h1, duplex_o)
    rd(8'h00, r);
    `CHK("ctrl", 16'h0140, r)
    rd(8'h10, r);
    `CHK("irq stat", 16'h0004, r)
    `CHK("irq masked", 1'h0, irq_o)
    wr(8'h14, 16'h0004);
    w(2);
    `CHK("irq", 1'h1, irq_o)
    wr(8'h10, 16'h0004);
    w(2);
    `CHK("irq", 1'h0, irq_o)
    $display("test soft reset done");
    an_done_i <= 1'h1;
    w(3);
    rd(8'h04, r);
    `CHK("an done", 16'h7969, r)
    an_done_i <= 1'h0;
    remote_fault_i <= 1'h1;
    w(1);
    remote_fault_i <= 1'h0;
    rd(8'h04, r);
    `CHK("fault set", 16'h7959, r)
    rd(8'h04, r);
    `CHK("fault clear", 16'h7949, r)
    rd(8'h10, r);
    `CHK("irq events", 16'h0003, r)
    $display("test status done");
    wr(8'h0C, 16'h0008);
    wr(8'h00, 16'h0940);
    w(2);
    `CHK("pdown", 1'h1, power_down_o)
    `CHK("mac up", 1'h1, rgmii_en_o)
    wr(8'h0C, 16'h0000);
    w(2);
    `CHK("mac down", 1'h0, rgmii_en_o)
    wr(8'h08, 16'h0004);
    wr(8'h00, 16'h0140);
    w(2);
    `CHK("pdown", 1'h1, power_down_o)
    r0 = restarts;
    wr(8'h08, 16'h0000);
    w(40);
    `CHK("pdown", 1'h0, power_down_o)
    `CHK("restarts", r0 + 2, restarts)
    `CHK("mac up", 1'h1, rgmii_en_o)
    $display("test power down done");
    r0 = restarts;
    rst_i <= 1'h1;
    w(12);
    rst_i <= 1'h0;
    w(3);
    `CHK("restarts", r0 + 1, restarts)
    `CHK("duplex", 1'h1, duplex_o)
    `CHK("speed", 2'h2, speed_o)
    rd(8'h00, r);
    `CHK("ctrl", 16'h0140, r)
    $display("test reset done");
    wrap_up;
  end
endmodule // cpcsr_top_tb
`default_nettype wire
